/* File: rtl/gpio_port_pkg.sv */
package gpio_port_pkg;

    // pin count and bus geometry
    localparam int          N_PINS   = 10;
    localparam int          ADDR_W   = 6;
    localparam int          DATA_W   = 32;
    localparam int          STRB_W   = DATA_W / 8;
    localparam int          STATUS_W = 1;

    // register byte offsets
    localparam logic [5:0]  OFF_CTRL       = 6'h00;
    localparam logic [5:0]  OFF_OPEN       = 6'h04;
    localparam logic [5:0]  OFF_DIR        = 6'h08;
    localparam logic [5:0]  OFF_OUT        = 6'h0C;
    localparam logic [5:0]  OFF_LEVEL      = 6'h10;
    localparam logic [5:0]  OFF_LCI_ROLE   = 6'h14;
    localparam logic [5:0]  OFF_HWAKE_ROLE = 6'h18;
    localparam logic [5:0]  OFF_HWAKE      = 6'h1C;
    localparam logic [5:0]  OFF_STATUS     = 6'h20;
    localparam logic [5:0]  OFF_MASK       = 6'h24;

    // field positions
    localparam int          CTRL_OPEN_BIT = 0;
    localparam int          HWAKE_BIT     = 0;
    localparam int          ST_WAKE_BIT   = 0;

    // reset values
    localparam logic [9:0]  PIN_RESET     = 10'h000;
    localparam logic [0:0]  STATUS_RESET  = 1'h0;

    // pins 1, 3, 4, 5 and 9 (bits 0, 2, 3, 4, 8) may wake the module
    localparam logic [9:0]  WAKE_CAPABLE  = 10'h11D;

    // bus responses
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // static configuration of one pin
    typedef struct packed {
        logic open;
        logic dir_out;
        logic out_level;
        logic role_lci;
        logic role_hwake;
        logic wake_capable;
    } pin_cfg_s;

    // what one pad is told to do
    typedef struct packed {
        logic out;
        logic oe_b;
        logic pull_down;
    } pad_drive_s;

endpackage : gpio_port_pkg

/* File: rtl/gpio_pin_cell.sv */
`timescale 1ns/10ps
`default_nettype none

module gpio_pin_cell
(
    input  wire logic                      clock,
    input  wire logic                      rst_b,
    input  wire logic                      clock_enable,
    input  wire gpio_port_pkg::pin_cfg_s   cfg,
    input  wire logic                      sleep_mode,
    input  wire logic                      hwake_level,
    input  wire logic                      pad_in,
    output gpio_port_pkg::pad_drive_s      drive,
    output logic                           level,
    output logic                           wake_edge
);

    typedef struct packed {
        logic                       sync1;
        logic                       sync2;
        logic                       sync3;
        gpio_port_pkg::pad_drive_s  drive;
    } cell_state_s;

    cell_state_s s;
    cell_state_s next_s;

    // pad control; the role outputs win over the plain direction bit
    always_comb
    begin
        next_s       = s;
        next_s.sync1 = pad_in;
        next_s.sync2 = s.sync1;
        next_s.sync3 = s.sync2;
        if (!cfg.open)
        begin
            next_s.drive = '{out: 1'b0, oe_b: 1'b1, pull_down: 1'b1};
        end
        else if (cfg.role_lci)
        begin
            next_s.drive = '{out: sleep_mode, oe_b: 1'b0, pull_down: 1'b0};
        end
        else if (cfg.role_hwake)
        begin
            next_s.drive = '{out: hwake_level, oe_b: 1'b0, pull_down: 1'b0};
        end
        else if (cfg.dir_out)
        begin
            next_s.drive = '{out: cfg.out_level, oe_b: 1'b0, pull_down: 1'b0};
        end
        else
        begin
            next_s.drive = '{out: 1'b0, oe_b: 1'b1, pull_down: 1'b0};
        end
    end

    // pad comes back in from outside the clock domain: two flops first
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s <= '{sync1: 1'b0, sync2: 1'b0, sync3: 1'b0,
                   drive: '{out: 1'b0, oe_b: 1'b1, pull_down: 1'b1}};
        end
        else if (clock_enable)
        begin
            s <= next_s;
        end
    end

    // edge looks only at the second and third flops, never the first
    assign drive     = s.drive;
    assign level     = s.sync2;
    assign wake_edge = sleep_mode & cfg.open & ~cfg.dir_out & ~cfg.role_lci & ~cfg.role_hwake
                       & cfg.wake_capable & (s.sync2 ^ s.sync3);

endmodule : gpio_pin_cell

`default_nettype wire

/* File: rtl/gpio_port_with_sleep_wake.sv */
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - ten general purpose pins, each one independently an input or an output
// - pin configuration is accepted only while the port driver is open
// - unconfigured or closed pins float with the pull-down enabled
// - an input pin floats with no pull resistor at all
// - any pin may take the low-current indicator or host wakeup role
// - in sleep, a level change on input pins 1,3,4,5,9 wakes the module
// - software can read the current level of every pin
// - low-current indicator pin drives high in sleep, low otherwise
// - host wakeup pin is active high: high requests wakeup
// - after reset the low-current indicator role is off on all pins
module gpio_port_with_sleep_wake
(
    input  wire logic                                   clock,
    input  wire logic                                   rst_b,
    input  wire logic                                   clock_enable,
    // axi4-lite write address
    input  wire logic                                   awvalid,
    output logic                                        awready,
    input  wire logic [gpio_port_pkg::ADDR_W-1:0]       awaddr,
    // axi4-lite write data
    input  wire logic                                   wvalid,
    output logic                                        wready,
    input  wire logic [gpio_port_pkg::DATA_W-1:0]       wdata,
    input  wire logic [gpio_port_pkg::STRB_W-1:0]       wstrb,
    // axi4-lite write response
    output logic                                        bvalid,
    input  wire logic                                   bready,
    output logic [1:0]                                  bresp,
    // axi4-lite read address
    input  wire logic                                   arvalid,
    output logic                                        arready,
    input  wire logic [gpio_port_pkg::ADDR_W-1:0]       araddr,
    // axi4-lite read data
    output logic                                        rvalid,
    input  wire logic                                   rready,
    output logic [gpio_port_pkg::DATA_W-1:0]            rdata,
    output logic [1:0]                                  rresp,
    // power state of the module
    input  wire logic                                   sleep_mode,
    output logic                                        module_wake,
    output logic                                        irq,
    // pads
    input  wire logic [gpio_port_pkg::N_PINS-1:0]       gp_pin_in,
    output logic [gpio_port_pkg::N_PINS-1:0]            gp_pin_out,
    output logic [gpio_port_pkg::N_PINS-1:0]            gp_pin_oe_b,
    output logic [gpio_port_pkg::N_PINS-1:0]            gp_pin_pull_down
);

    // short local names for the package geometry
    localparam int NP = gpio_port_pkg::N_PINS;
    localparam int DW = gpio_port_pkg::DATA_W;
    localparam int AW = gpio_port_pkg::ADDR_W;
    localparam int SW = gpio_port_pkg::STATUS_W;

    typedef struct packed {
        logic                               drv_open;
        logic [NP-1:0]                      pin_open;
        logic [NP-1:0]                      dir_out;
        logic [NP-1:0]                      out_level;
        logic [NP-1:0]                      role_lci;
        logic [NP-1:0]                      role_hwake;
        logic                               hwake;
        logic [SW-1:0]                      status;
        logic [SW-1:0]                      mask;
        logic                               wake;
        logic                               aw_got;
        logic [AW-1:0]                      wr_addr;
        logic                               w_got;
        logic [DW-1:0]                      wr_data;
        logic [gpio_port_pkg::STRB_W-1:0]   wr_strb;
        logic                               bvalid;
        logic [1:0]                         bresp;
        logic                               rvalid;
        logic [DW-1:0]                      rdata;
        logic [1:0]                         rresp;
    } port_state_s;

    port_state_s s;
    port_state_s next_s;

    // per-pin cell views and handshake strobes
    logic [NP-1:0]                          pin_level;
    logic [NP-1:0]                          pin_edge;
    gpio_port_pkg::pad_drive_s              pad_drive [NP];
    gpio_port_pkg::pin_cfg_s                pin_cfg [NP];
    logic                                   aw_take;
    logic                                   w_take;
    logic                                   ar_take;
    logic                                   wr_fire;
    logic [DW:0]                            wr_view;
    logic [DW:0]                            rd_view;
    logic [DW-1:0]                          wv;
    logic [SW-1:0]                          st_set;
    logic [SW-1:0]                          st_clear;

    // register view at an address: top bit is the hit flag, unused bits read zero
    function automatic logic [DW:0] reg_view(input logic [AW-1:0] a,
                                             input port_state_s   st,
                                             input logic [NP-1:0] lvl);
        logic [DW:0] v;
        v = '0;
        v[DW] = 1'b1;
        case (a)
            gpio_port_pkg::OFF_CTRL:       v[gpio_port_pkg::CTRL_OPEN_BIT] = st.drv_open;
            gpio_port_pkg::OFF_OPEN:       v[NP-1:0] = st.pin_open;
            gpio_port_pkg::OFF_DIR:        v[NP-1:0] = st.dir_out;
            gpio_port_pkg::OFF_OUT:        v[NP-1:0] = st.out_level;
            gpio_port_pkg::OFF_LEVEL:      v[NP-1:0] = lvl;
            gpio_port_pkg::OFF_LCI_ROLE:   v[NP-1:0] = st.role_lci;
            gpio_port_pkg::OFF_HWAKE_ROLE: v[NP-1:0] = st.role_hwake;
            gpio_port_pkg::OFF_HWAKE:      v[gpio_port_pkg::HWAKE_BIT] = st.hwake;
            gpio_port_pkg::OFF_STATUS:     v[SW-1:0] = st.status;
            gpio_port_pkg::OFF_MASK:       v[SW-1:0] = st.mask;
            default:                       v[DW] = 1'b0;
        endcase
        return v;
    endfunction : reg_view

    // merge written bytes over the present value, lane by lane
    function automatic logic [DW-1:0] merge(input logic [DW-1:0]                    old_v,
                                            input logic [DW-1:0]                    new_v,
                                            input logic [gpio_port_pkg::STRB_W-1:0] strb);
        logic [DW-1:0] m;
        m = old_v;
        for (int i = 0; i < gpio_port_pkg::STRB_W; i++)
        begin
            if (strb[i])
            begin
                m[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return m;
    endfunction : merge

    // a locked field keeps its bit wherever the pin is still open
    function automatic logic [NP-1:0] keep_open(input logic [NP-1:0] old_v,
                                                input logic [NP-1:0] new_v,
                                                input logic [NP-1:0] open_v);
        return (old_v & open_v) | (new_v & ~open_v);
    endfunction : keep_open

    // one cell per pad
    generate
        for (genvar g = 0; g < NP; g++)
        begin : g_pin
            assign pin_cfg[g] = '{open:         s.drv_open & s.pin_open[g],
                                  dir_out:      s.dir_out[g],
                                  out_level:    s.out_level[g],
                                  role_lci:     s.role_lci[g],
                                  role_hwake:   s.role_hwake[g],
                                  wake_capable: gpio_port_pkg::WAKE_CAPABLE[g]};

            gpio_pin_cell u_cell
            (
                .clock        (clock),
                .rst_b        (rst_b),
                .clock_enable (clock_enable),
                .cfg          (pin_cfg[g]),
                .sleep_mode   (sleep_mode),
                .hwake_level  (s.hwake),
                .pad_in       (gp_pin_in[g]),
                .drive        (pad_drive[g]),
                .level        (pin_level[g]),
                .wake_edge    (pin_edge[g])
            );

            assign gp_pin_out[g]       = pad_drive[g].out;
            assign gp_pin_oe_b[g]      = pad_drive[g].oe_b;
            assign gp_pin_pull_down[g] = pad_drive[g].pull_down;
        end
    endgenerate

    // readies drop while frozen so no handshake is seen that the state misses
    assign awready = clock_enable & ~s.aw_got & ~s.bvalid;
    assign wready  = clock_enable & ~s.w_got & ~s.bvalid;
    assign arready = clock_enable & ~s.rvalid;
    assign aw_take = awvalid & awready;
    assign w_take  = wvalid & wready;
    assign ar_take = arvalid & arready;
    assign wr_fire = s.aw_got & s.w_got & ~s.bvalid;

    // views for the pending write and the incoming read
    assign wr_view = reg_view(s.wr_addr, s, pin_level);
    assign rd_view = reg_view(araddr, s, pin_level);
    assign wv      = merge(wr_view[DW-1:0], s.wr_data, s.wr_strb);

    // sticky events; a read of status clears, but a new event in that cycle wins
    assign st_set   = SW'(|pin_edge);
    assign st_clear = (ar_take && araddr == gpio_port_pkg::OFF_STATUS) ? s.status : '0;

    always_comb
    begin
        next_s        = s;
        next_s.wake   = |pin_edge;
        next_s.status = (s.status & ~st_clear) | st_set;

        // address and data are taken in either order and held until the write
        if (aw_take)
        begin
            next_s.aw_got  = 1'b1;
            next_s.wr_addr = awaddr;
        end

        if (w_take)
        begin
            next_s.w_got   = 1'b1;
            next_s.wr_data = wdata;
            next_s.wr_strb = wstrb;
        end

        if (s.bvalid && bready)
        begin
            next_s.bvalid = 1'b0;
        end

        // commit a write once both halves are in
        if (wr_fire)
        begin
            next_s.aw_got = 1'b0;
            next_s.w_got  = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = wr_view[DW] ? gpio_port_pkg::RESP_OKAY : gpio_port_pkg::RESP_SLVERR;

            case (s.wr_addr)
                gpio_port_pkg::OFF_CTRL:
                begin
                    next_s.drv_open = wv[gpio_port_pkg::CTRL_OPEN_BIT];
                    // closing the driver closes every pin with it
                    if (!wv[gpio_port_pkg::CTRL_OPEN_BIT])
                    begin
                        next_s.pin_open = gpio_port_pkg::PIN_RESET;
                    end
                end

                gpio_port_pkg::OFF_OPEN:
                begin
                    if (s.drv_open)
                    begin
                        next_s.pin_open = wv[NP-1:0];
                    end
                end

                gpio_port_pkg::OFF_DIR:
                begin
                    if (s.drv_open)
                    begin
                        next_s.dir_out = keep_open(s.dir_out, wv[NP-1:0], s.pin_open);
                    end
                end

                gpio_port_pkg::OFF_OUT:
                begin
                    if (s.drv_open)
                    begin
                        next_s.out_level = wv[NP-1:0];
                    end
                end

                gpio_port_pkg::OFF_LCI_ROLE:
                begin
                    if (s.drv_open)
                    begin
                        next_s.role_lci = keep_open(s.role_lci, wv[NP-1:0], s.pin_open);
                    end
                end

                gpio_port_pkg::OFF_HWAKE_ROLE:
                begin
                    if (s.drv_open)
                    begin
                        next_s.role_hwake = keep_open(s.role_hwake, wv[NP-1:0], s.pin_open);
                    end
                end

                gpio_port_pkg::OFF_HWAKE:
                begin
                    next_s.hwake = wv[gpio_port_pkg::HWAKE_BIT];
                end

                gpio_port_pkg::OFF_MASK:
                begin
                    next_s.mask = wv[SW-1:0];
                end

                default:
                begin
                    next_s.mask = s.mask; // read-only or unmapped: nothing stored
                end
            endcase
        end

        // reads answer in the cycle after the address is taken
        if (s.rvalid && rready)
        begin
            next_s.rvalid = 1'b0;
        end

        if (ar_take)
        begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = rd_view[DW-1:0];
            next_s.rresp  = rd_view[DW] ? gpio_port_pkg::RESP_OKAY : gpio_port_pkg::RESP_SLVERR;
        end
    end

    // every control bit clears, so no pin is open or in a role after reset
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s            <= '0;
            s.pin_open   <= gpio_port_pkg::PIN_RESET;
            s.dir_out    <= gpio_port_pkg::PIN_RESET;
            s.out_level  <= gpio_port_pkg::PIN_RESET;
            s.role_lci   <= gpio_port_pkg::PIN_RESET;
            s.role_hwake <= gpio_port_pkg::PIN_RESET;
            s.status     <= gpio_port_pkg::STATUS_RESET;
        end
        else if (clock_enable)
        begin
            s <= next_s;
        end
    end

    // outputs straight from state
    assign bvalid      = s.bvalid;
    assign bresp       = s.bresp;
    assign rvalid      = s.rvalid;
    assign rdata       = s.rdata;
    assign rresp       = s.rresp;
    assign module_wake = s.wake;
    assign irq         = |(s.status & s.mask);

endmodule : gpio_port_with_sleep_wake

`default_nettype wire

/* File: bench/gpio_port_monitor.sv */
`timescale 1ns/10ps
`default_nettype none

module gpio_port_monitor
(
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic        sleep_mode,
    input wire logic        module_wake,
    input wire logic [9:0]  gp_pin_out,
    input wire logic [9:0]  gp_pin_oe_b,
    input wire logic [9:0]  gp_pin_pull_down
);
    // every check shares the one clock and the async reset
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    reset_pads_a : assert property
        ($rose(rst_b) |-> gp_pin_oe_b == 10'h3FF && gp_pin_pull_down == 10'h3FF && gp_pin_out == 10'h000)
        else $error("pads not floating with pull-down after reset");
    pull_float_a : assert property
        ((gp_pin_pull_down & ~gp_pin_oe_b) == 10'h000)
        else $error("pull-down enabled on a driven pad");
    wake_pulse_a : assert property
        (module_wake |=> !module_wake)
        else $error("wake pulse longer than one cycle");
    wake_sleep_a : assert property
        (module_wake |-> $past(sleep_mode))
        else $error("wake raised while not asleep");
    rd_latency_a : assert property
        (arvalid && arready |=> rvalid)
        else $error("read answer late");
    wr_latency_a : assert property
        (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write answer late");
    resp_once_a : assert property
        (rvalid && rready |=> !rvalid)
        else $error("read response repeated");
    bresp_once_a : assert property
        (bvalid && bready |=> !bvalid)
        else $error("write response repeated");
    busy_refuse_a : assert property
        ((bvalid |-> !awready && !wready) and (rvalid |-> !arready))
        else $error("request taken while answer pending");
endmodule : gpio_port_monitor

bind gpio_port_with_sleep_wake gpio_port_monitor u_mon (.clock, .rst_b, .awvalid, .awready, .wvalid, .wready,
    .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .sleep_mode, .module_wake, .gp_pin_out,
    .gp_pin_oe_b, .gp_pin_pull_down);

`default_nettype wire

/* File: bench/gpio_ext_devices.sv */
`timescale 1ns/10ps
`default_nettype none

module gpio_ext_devices
(
    input  wire logic        clock,
    input  wire logic [9:0]  pin_out,
    input  wire logic [9:0]  pin_oe_b,
    input  wire logic [9:0]  pin_pull_down,
    input  wire logic [9:0]  ext_en,
    input  wire logic [9:0]  ext_val,
    output logic [9:0]       pin_level
);
    // a floating unpulled pad wanders; it never reads clean
    logic [9:0] drift = 10'h155;
    always @(posedge clock) drift <= ~drift;

    // wire level: module drive, then external drive, then pull-down, else drift
    always_comb
    begin
        for (int i = 0; i < 10; i++)
            pin_level[i] = !pin_oe_b[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                           pin_pull_down[i] ? 1'b0 : drift[i];
    end
endmodule : gpio_ext_devices

`default_nettype wire

/* File: bench/test_gpio_port_with_sleep_wake.sv */
`timescale 1ns/10ps
`default_nettype none

module test_gpio_port_with_sleep_wake;
    logic clock = 1'b0, rst_b = 1'b0, clock_enable = 1'b1, sleep_mode = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, module_wake, irq;
    logic [5:0] awaddr = 6'h00, araddr = 6'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp, rsp;
    logic [9:0] ext_en = 10'h000, ext_val = 10'h000, pin_level, gp_pin_out, gp_pin_oe_b, gp_pin_pull_down;
    int miscompares = 0, samples_checked = 0, wake_count = 0;

    always #4 clock = ~clock;

    gpio_port_with_sleep_wake u_dut (.clock(clock), .rst_b(rst_b), .clock_enable(clock_enable),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .sleep_mode(sleep_mode), .module_wake(module_wake), .irq(irq),
        .gp_pin_in(pin_level), .gp_pin_out(gp_pin_out), .gp_pin_oe_b(gp_pin_oe_b),
        .gp_pin_pull_down(gp_pin_pull_down));

    gpio_ext_devices u_ext (.clock(clock), .pin_out(gp_pin_out), .pin_oe_b(gp_pin_oe_b),
        .pin_pull_down(gp_pin_pull_down), .ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_level));

    // one-cycle wake pulse: counted, not sampled
    always @(posedge clock) if (module_wake === 1'b1) wake_count <= wake_count + 1;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : settle

    // both halves offered together, each dropped once taken; waits only on the watchdog
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clock);
        awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= 4'hF; bready <= 1'b1;
        while (1)
        begin
            @(posedge clock);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        rsp = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd_reg(input logic [5:0] a);
        @(posedge clock);
        arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
        while (1)
        begin
            @(posedge clock);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask : rd_reg

    task automatic t_locked;
        settle(1);
        chk("pull after reset", 32'h3FF, 32'(gp_pin_pull_down));
        rd_reg(gpio_port_pkg::OFF_LCI_ROLE); chk("lci role", 32'h0, rd);
        wr(gpio_port_pkg::OFF_DIR, 32'h3FF);
        wr(gpio_port_pkg::OFF_OPEN, 32'h3FF);
        rd_reg(gpio_port_pkg::OFF_DIR); chk("dir unopened", 32'h0, rd);
        settle(2); chk("oe_b unopened", 32'h3FF, 32'(gp_pin_oe_b));
    endtask : t_locked

    task automatic t_config;
        wr(gpio_port_pkg::OFF_CTRL, 32'h1);
        wr(gpio_port_pkg::OFF_DIR, 32'h3F0);
        wr(gpio_port_pkg::OFF_OUT, 32'h2A0);
        wr(gpio_port_pkg::OFF_OPEN, 32'h3FF);
        settle(2);
        chk("oe_b", 32'h00F, 32'(gp_pin_oe_b));
        chk("pull inputs", 32'h0, 32'(gp_pin_pull_down));
        chk("out", 32'h2A0, 32'(gp_pin_out & 10'h3F0));
        wr(gpio_port_pkg::OFF_DIR, 32'h0); settle(2);
        rd_reg(gpio_port_pkg::OFF_DIR); chk("dir held", 32'h3F0, rd);
        chk("oe_b held", 32'h00F, 32'(gp_pin_oe_b));
        wr(gpio_port_pkg::OFF_OPEN, 32'h3FE); settle(2);
        chk("pull closed", 32'h001, 32'(gp_pin_pull_down));
    endtask : t_config

    task automatic t_level;
        @(posedge clock);
        ext_en <= 10'h00E;
        ext_val <= 10'h00A;
        settle(4);
        rd_reg(gpio_port_pkg::OFF_LEVEL); chk("level", 32'h2AA, rd);
    endtask : t_level

    // pin index 1 cannot wake, index 2 and 3 can; the mask gates only irq
    task automatic t_wake;
        wr(gpio_port_pkg::OFF_MASK, 32'h1);
        @(posedge clock) sleep_mode <= 1'b1;
        @(posedge clock) ext_val <= 10'h008;
        settle(8); chk("no wake", 32'h0, 32'(wake_count));
        @(posedge clock) ext_val <= 10'h00C;
        settle(8); chk("wake", 32'h1, 32'(wake_count));
        chk("irq set", 32'h1, 32'(irq));
        rd_reg(gpio_port_pkg::OFF_STATUS); chk("status", 32'h1, rd);
        settle(1); chk("irq clear", 32'h0, 32'(irq));
        wr(gpio_port_pkg::OFF_MASK, 32'h0);
        @(posedge clock) ext_val <= 10'h004;
        settle(8); chk("wake masked", 32'h2, 32'(wake_count));
        chk("irq masked", 32'h0, 32'(irq));
        rd_reg(gpio_port_pkg::OFF_STATUS); chk("status masked", 32'h1, rd);
        @(posedge clock) sleep_mode <= 1'b0;
        @(posedge clock) ext_val <= 10'h00C;
        settle(8); chk("awake", 32'h2, 32'(wake_count));
    endtask : t_wake

    task automatic t_roles;
        wr(gpio_port_pkg::OFF_OPEN, 32'h3CE);
        wr(gpio_port_pkg::OFF_LCI_ROLE, 32'h010);
        wr(gpio_port_pkg::OFF_HWAKE_ROLE, 32'h020);
        wr(gpio_port_pkg::OFF_HWAKE, 32'h1);
        wr(gpio_port_pkg::OFF_OPEN, 32'h3FE);
        settle(2);
        chk("role oe_b", 32'h00F, 32'(gp_pin_oe_b));
        chk("roles awake", 32'h020, 32'(gp_pin_out & 10'h030));
        @(posedge clock) sleep_mode <= 1'b1;
        settle(2); chk("roles asleep", 32'h030, 32'(gp_pin_out & 10'h030));
        wr(gpio_port_pkg::OFF_HWAKE, 32'h0);
        settle(2); chk("host wake off", 32'h010, 32'(gp_pin_out & 10'h030));
        @(posedge clock) sleep_mode <= 1'b0;
    endtask : t_roles

    task automatic t_errors;
        rd_reg(6'h28); chk("unmapped rresp", 32'h2, 32'(rsp)); chk("unmapped rdata", 32'h0, rd);
        wr(6'h28, 32'hFFFFFFFF); chk("unmapped bresp", 32'h2, 32'(rsp));
        rd_reg(6'h06); chk("unaligned rresp", 32'h2, 32'(rsp));
        wr(gpio_port_pkg::OFF_STATUS, 32'h1); chk("status write", 32'h0, 32'(rsp));
        wr(gpio_port_pkg::OFF_CTRL, 32'h0); settle(2); chk("drv closed", 32'h3FF, 32'(gp_pin_pull_down));
        @(posedge clock) clock_enable <= 1'b0;
        settle(1); chk("frozen ready", 32'h0, 32'({awready, wready, arready}));
        @(posedge clock) clock_enable <= 1'b1;
    endtask : t_errors

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    // a hung handshake would otherwise stall forever
    initial
    begin
        repeat (20000) @(posedge clock);
        miscompares++;
        close_out();
    end

    initial
    begin
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        t_locked();
        t_config();
        t_level();
        t_wake();
        t_roles();
        t_errors();
        close_out();
    end
endmodule : test_gpio_port_with_sleep_wake

`default_nettype wire
